// file: shared/cg3_cfg_pkg.sv
`default_nettype none
package cg3_cfg_pkg;
  // =====================================================
  // register map
  localparam logic [5:0] RATE_ADDR = 6'h17;
  localparam logic [5:0] PHASE_ADDR = 6'h18;
  localparam logic [5:0] FILTER_ADDR = 6'h19;
  localparam logic [15:0] RATE_RESET = 16'hbb80;
  localparam logic [15:0] PHASE_RESET = 16'h0000;
  localparam logic [15:0] FILTER_RESET = 16'h0000;
  localparam logic [15:0] PHASE_MASK = 16'h01ff;
  localparam logic [15:0] FILTER_MASK = 16'hc3f3;
  // =====================================================
  // field positions
  localparam int PH_DIR_BIT = 8;
  localparam int FL_RESAMP_BIT = 15;
  localparam int FL_MIX_BIT = 14;
  localparam int FL_DAC2_BIT = 9;
  localparam int FL_DAC1_BIT = 8;
  localparam int FL_RSRC_LSB = 6;
  localparam int FL_LSRC_LSB = 4;
  localparam int FL_RADC_BIT = 1;
  localparam int FL_LADC_BIT = 0;
  // =====================================================
  // timing: phase steps at 3.072 MHz from a 250 MHz master
  localparam int MCLK_KHZ = 250000;
  localparam int STEP_KHZ = 3072;
  localparam int STEP_CYCLES = MCLK_KHZ / STEP_KHZ;

  typedef struct packed {
    logic resampler_filter_mode;
    logic dac_digital_mix_en;
    logic second_dac_filter_sel;
    logic first_dac_filter_sel;
    logic [1:0] right_adc_source_sel;
    logic [1:0] left_adc_source_sel;
    logic right_adc_filter_sel;
    logic left_adc_filter_sel;
  } filter_cfg_t;

  typedef struct packed {
    logic dac1_pd;
    logic dac2_pd;
    logic adl_pd;
    logic adr_pd;
  } chan_pd_t;
endpackage
`default_nettype wire

// file: hdl/cg3_rate_phase_filter_cfg.sv
`timescale 1ns/1ps
`default_nettype none
module cg3_rate_phase_filter_cfg
  import cg3_cfg_pkg::*;
#(
  parameter int STEP_DIV = STEP_CYCLES
)(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic reset_pin_n,
  input wire logic powerdown_pin_n,
  input wire logic gen3_enable,
  input wire logic gen3_sync_reference_sel,
  input wire logic converter_powerdown_bit,
  input wire chan_pd_t chan_pd,
  input wire logic master_mode,
  input wire logic frame_start,
  input wire logic slave_frame_sync_in,
  input wire logic wr_en,
  input wire logic [5:0] wr_addr,
  input wire logic [15:0] wr_data,
  input wire logic rd_en,
  input wire logic [5:0] rd_addr,
  input wire logic slot1_start,
  output logic [15:0] rd_data_ff,
  output logic [15:0] echo_data_ff,
  output logic echo_valid_ff,
  output logic [15:0] gen3_rate_word_ff,
  output logic gen3_rate_active_ff,
  output logic gen3_phase_direction_ff,
  output logic phase_step_ff,
  output filter_cfg_t filter_cfg_ff,
  output logic [1:0] right_path_ff,
  output logic [1:0] left_path_ff
);
  // =====================================================
  // pin synchronisers: change counts when stages two and three agree
  logic [2:0] rst_sync_ff;
  logic [2:0] pd_sync_ff;
  logic [2:0] fs_sync_ff;
  logic rst_lvl_ff;
  logic pd_lvl_ff;
  logic fs_lvl_ff;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      rst_sync_ff <= 3'h0;
      pd_sync_ff <= 3'h0;
      fs_sync_ff <= 3'h0;
      rst_lvl_ff <= 1'b0;
      pd_lvl_ff <= 1'b0;
      fs_lvl_ff <= 1'b0;
    end
    else
    begin
      rst_sync_ff <= {rst_sync_ff[1:0], reset_pin_n};
      pd_sync_ff <= {pd_sync_ff[1:0], powerdown_pin_n};
      fs_sync_ff <= {fs_sync_ff[1:0], slave_frame_sync_in};
      if (rst_sync_ff[1] == rst_sync_ff[2])
        rst_lvl_ff <= rst_sync_ff[2];
      if (pd_sync_ff[1] == pd_sync_ff[2])
        pd_lvl_ff <= pd_sync_ff[2];
      if (fs_sync_ff[1] == fs_sync_ff[2])
        fs_lvl_ff <= fs_sync_ff[2];
    end
  end

  logic pins_hold;
  logic fs_rise;
  logic sample_now;
  assign pins_hold = !rst_lvl_ff || !pd_lvl_ff;
  assign fs_rise = (fs_sync_ff[1] == fs_sync_ff[2]) && fs_sync_ff[2]
    && !fs_lvl_ff;
  // master samples at slot 0 start, slave at frame sync arrival
  assign sample_now = master_mode ? frame_start : fs_rise;

  logic wr_rate;
  logic wr_phase;
  logic wr_filter;
  assign wr_rate = wr_en && (wr_addr == RATE_ADDR);
  assign wr_phase = wr_en && (wr_addr == PHASE_ADDR);
  assign wr_filter = wr_en && (wr_addr == FILTER_ADDR);

  // =====================================================
  // rate word
  always_ff @(posedge mclk)
  begin
    if (sys_rst || pins_hold)
      gen3_rate_word_ff <= RATE_RESET;
    else if (wr_rate)
      gen3_rate_word_ff <= wr_data;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      gen3_rate_active_ff <= 1'b0;
    else
      gen3_rate_active_ff <= !gen3_sync_reference_sel;
  end

  // =====================================================
  // phase shift: magnitude drains one step per tick
  logic [7:0] step_cnt_ff;
  logic [7:0] phase_mag_ff;
  logic tick;
  logic phase_hold;
  assign tick = (step_cnt_ff == 8'(STEP_DIV - 1));
  assign phase_hold = pins_hold || !gen3_enable;

  always_ff @(posedge mclk)
  begin
    if (sys_rst || tick)
      step_cnt_ff <= 8'h00;
    else
      step_cnt_ff <= step_cnt_ff + 8'h01;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst || phase_hold)
    begin
      phase_mag_ff <= PHASE_RESET[7:0];
      gen3_phase_direction_ff <= PHASE_RESET[PH_DIR_BIT];
    end
    else if (wr_phase)
    begin
      phase_mag_ff <= wr_data[7:0];
      gen3_phase_direction_ff <= wr_data[PH_DIR_BIT];
    end
    else if (tick && (phase_mag_ff != 8'h00))
      phase_mag_ff <= phase_mag_ff - 8'h01;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      phase_step_ff <= 1'b0;
    else
      phase_step_ff <= tick && (phase_mag_ff != 8'h00) && !phase_hold
        && !wr_phase;
  end

  logic [15:0] phase_snap_ff;
  always_ff @(posedge mclk)
  begin
    if (sys_rst || phase_hold)
      phase_snap_ff <= PHASE_RESET;
    else if (sample_now)
      phase_snap_ff <= {7'h00, gen3_phase_direction_ff, phase_mag_ff};
  end

  // =====================================================
  // filter and path select
  logic [15:0] filter_word;
  logic [15:0] allow_mask;
  logic [15:0] nxt_filter;
  logic all_pd;
  assign filter_word = {filter_cfg_ff[9:8], 4'h0, filter_cfg_ff[7:2],
    2'b00, filter_cfg_ff[1:0]};
  assign all_pd = chan_pd.dac1_pd && chan_pd.dac2_pd && chan_pd.adl_pd
    && chan_pd.adr_pd;

  always_comb
  begin
    allow_mask = FILTER_MASK;
    allow_mask[FL_RESAMP_BIT] = all_pd;
    allow_mask[FL_MIX_BIT] = chan_pd.dac1_pd && chan_pd.dac2_pd;
    allow_mask[FL_DAC2_BIT] = chan_pd.dac2_pd;
    allow_mask[FL_DAC1_BIT] = chan_pd.dac1_pd;
    allow_mask[FL_RADC_BIT] = chan_pd.adr_pd;
    allow_mask[FL_LADC_BIT] = chan_pd.adl_pd;
    nxt_filter = (wr_data & allow_mask) | (filter_word & ~allow_mask);
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst || pins_hold || converter_powerdown_bit)
      filter_cfg_ff <= filter_cfg_t'(10'h000);
    else if (wr_filter)
      filter_cfg_ff <= {nxt_filter[15:14], nxt_filter[9:4], nxt_filter[1:0]};
  end

  // source paths: 00 analog, 10 dac1, 11 dac2; reserved code stays analog
  function automatic logic [1:0] path_of(input logic [1:0] sel);
    path_of = (sel == 2'b01) ? 2'b00 : sel;
  endfunction

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      right_path_ff <= 2'b00;
      left_path_ff <= 2'b00;
    end
    else
    begin
      // resampler mode alone never opens a path
      right_path_ff <= path_of(filter_cfg_ff.right_adc_source_sel);
      left_path_ff <= path_of(filter_cfg_ff.left_adc_source_sel);
    end
  end

  // =====================================================
  // read port and write echo
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      rd_data_ff <= 16'h0000;
    else if (rd_en)
      unique case (rd_addr)
        RATE_ADDR: rd_data_ff <= gen3_rate_word_ff;
        PHASE_ADDR: rd_data_ff <= phase_snap_ff;
        FILTER_ADDR: rd_data_ff <= filter_word;
        default: rd_data_ff <= 16'h0000;
      endcase
  end

  logic [15:0] echo_hold_ff;
  logic echo_pend_ff;
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      echo_hold_ff <= 16'h0000;
      echo_pend_ff <= 1'b0;
    end
    else if (wr_rate || wr_phase || wr_filter)
    begin
      echo_pend_ff <= 1'b1;
      if (wr_rate)
        echo_hold_ff <= gen3_rate_word_ff;
      else if (wr_phase)
        echo_hold_ff <= {7'h00, gen3_phase_direction_ff, phase_mag_ff};
      else
        echo_hold_ff <= filter_word;
    end
    else if (slot1_start)
      echo_pend_ff <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      echo_data_ff <= 16'h0000;
      echo_valid_ff <= 1'b0;
    end
    else
    begin
      echo_valid_ff <= slot1_start && echo_pend_ff;
      if (slot1_start && echo_pend_ff)
        echo_data_ff <= echo_hold_ff;
    end
  end

  // =====================================================
  // checks
  property p_rate_hold;
    @(posedge mclk) disable iff (sys_rst)
    pins_hold |=> gen3_rate_word_ff == RATE_RESET;
  endproperty
  a_rate_hold: assert property (p_rate_hold)
    else $error("rate word not held at default");

  property p_rate_write;
    @(posedge mclk) disable iff (sys_rst)
    wr_rate && !pins_hold |=> gen3_rate_word_ff == $past(wr_data);
  endproperty
  a_rate_write: assert property (p_rate_write)
    else $error("rate write lost");

  property p_phase_clear;
    @(posedge mclk) disable iff (sys_rst)
    !gen3_enable |=> phase_mag_ff == 8'h00;
  endproperty
  a_phase_clear: assert property (p_phase_clear)
    else $error("phase not cleared");

  property p_phase_dec;
    @(posedge mclk) disable iff (sys_rst)
    tick && phase_mag_ff != 8'h00 && !phase_hold && !wr_phase
      |=> phase_mag_ff == $past(phase_mag_ff) - 8'h01;
  endproperty
  a_phase_dec: assert property (p_phase_dec)
    else $error("phase step missed");

  property p_phase_over;
    @(posedge mclk) disable iff (sys_rst)
    wr_phase && !phase_hold |=> phase_mag_ff == $past(wr_data[7:0]);
  endproperty
  a_phase_over: assert property (p_phase_over)
    else $error("phase overwrite lost");

  property p_resamp_lock;
    @(posedge mclk) disable iff (sys_rst)
    wr_filter && !all_pd && !converter_powerdown_bit && !pins_hold
      |=> $stable(filter_cfg_ff.resampler_filter_mode);
  endproperty
  a_resamp_lock: assert property (p_resamp_lock)
    else $error("resampler bit changed while powered");

  property p_mix_lock;
    @(posedge mclk) disable iff (sys_rst)
    wr_filter && !(chan_pd.dac1_pd && chan_pd.dac2_pd)
      && !converter_powerdown_bit && !pins_hold
      |=> $stable(filter_cfg_ff.dac_digital_mix_en);
  endproperty
  a_mix_lock: assert property (p_mix_lock)
    else $error("mix bit changed while a dac powered");

  property p_filter_clear;
    @(posedge mclk) disable iff (sys_rst)
    converter_powerdown_bit |=> filter_cfg_ff == 10'h000;
  endproperty
  a_filter_clear: assert property (p_filter_clear)
    else $error("filter register not cleared");

  property p_echo;
    @(posedge mclk) disable iff (sys_rst)
    wr_rate ##1 (!wr_en && !slot1_start) [*1] ##1 slot1_start
      |=> echo_valid_ff && echo_data_ff == $past(gen3_rate_word_ff, 3);
  endproperty
  a_echo: assert property (p_echo)
    else $error("echo value wrong");
endmodule // cg3_rate_phase_filter_cfg
`default_nettype wire

// file: bench/host_dsp_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_dsp_model
  import cg3_cfg_pkg::*;
(
  input wire logic mclk,
  input wire logic [15:0] rd_data_ff,
  output logic frame_start,
  output logic slot1_start,
  output logic wr_en,
  output logic [5:0] wr_addr,
  output logic [15:0] wr_data,
  output logic rd_en,
  output logic [5:0] rd_addr
);
  // =====================================================
  // frame timing: 32-cycle frame, slot 1 four cycles in
  logic [4:0] slot_cnt = 5'h00;
  initial
  begin
    {frame_start, slot1_start, wr_en, rd_en} = 4'h0;
    {wr_addr, rd_addr, wr_data} = 28'h0000000;
  end
  always @(posedge mclk)
  begin
    slot_cnt <= slot_cnt + 5'h01;
    frame_start <= (slot_cnt == 5'h00);
    slot1_start <= (slot_cnt == 5'h04);
  end
  // =====================================================
  // register access; the host never sets reserved bits
  task automatic write_reg(input logic [5:0] a, input logic [15:0] d);
    @(posedge mclk);
    wr_en <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge mclk);
    wr_en <= 1'b0;
    // a non-mapped value would linger as a stale bus pattern
    wr_data <= ~d;
  endtask
  task automatic read_reg(input logic [5:0] a, output logic [15:0] d);
    @(posedge mclk);
    rd_en <= 1'b1;
    rd_addr <= a;
    @(posedge mclk);
    rd_en <= 1'b0;
    @(posedge mclk);
    #1 d = rd_data_ff;
  endtask
endmodule // host_dsp_model
`default_nettype wire

// file: bench/cg3_rate_phase_filter_cfg_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cg3_rate_phase_filter_cfg_tb;
  import cg3_cfg_pkg::*;
  logic mclk, sys_rst, reset_pin_n, powerdown_pin_n, gen3_enable;
  logic sync_ref, conv_pd, master_mode, slave_fs;
  chan_pd_t chan_pd;
  logic frame_start, slot1_start, wr_en, rd_en, echo_valid_ff;
  logic [5:0] wr_addr, rd_addr;
  logic [15:0] wr_data, rd_data_ff, echo_data_ff, rate_ff, v;
  logic rate_act_ff, dir_ff, step_ff;
  filter_cfg_t filter_cfg_ff;
  logic [1:0] rpath_ff, lpath_ff;
  int miscompares = 0, tests_run = 0, steps = 0;
  host_dsp_model host (.mclk(mclk), .rd_data_ff(rd_data_ff),
    .frame_start(frame_start), .slot1_start(slot1_start), .wr_en(wr_en),
    .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr));
  cg3_rate_phase_filter_cfg #(.STEP_DIV(4)) DUT (.mclk(mclk),
    .sys_rst(sys_rst), .reset_pin_n(reset_pin_n),
    .powerdown_pin_n(powerdown_pin_n), .gen3_enable(gen3_enable),
    .gen3_sync_reference_sel(sync_ref), .converter_powerdown_bit(conv_pd),
    .chan_pd(chan_pd), .master_mode(master_mode),
    .frame_start(frame_start), .slave_frame_sync_in(slave_fs),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en),
    .rd_addr(rd_addr), .slot1_start(slot1_start), .rd_data_ff(rd_data_ff),
    .echo_data_ff(echo_data_ff), .echo_valid_ff(echo_valid_ff),
    .gen3_rate_word_ff(rate_ff), .gen3_rate_active_ff(rate_act_ff),
    .gen3_phase_direction_ff(dir_ff), .phase_step_ff(step_ff),
    .filter_cfg_ff(filter_cfg_ff), .right_path_ff(rpath_ff),
    .left_path_ff(lpath_ff));
  // =====================================================
  // clock, step counter, checks
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk)
    if (step_ff === 1'b1)
      steps <= steps + 1;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    if (miscompares == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // =====================================================
  // scenarios
  task automatic t_rate();
    int n;
    host.read_reg(RATE_ADDR, v);
    check(v, RATE_RESET);
    // land the write two cycles before slot 1, the spacing the echo check needs, so it fires
    @(posedge mclk);
    while (host.slot_cnt !== 5'h01)
      @(posedge mclk);
    host.write_reg(RATE_ADDR, 16'h0fa0);
    n = 0;
    while (echo_valid_ff !== 1'b1 && n < 100)
    begin
      @(posedge mclk);
      n++;
    end
    check(echo_data_ff, RATE_RESET);
    check(rate_ff, 16'h0fa0);
    check({15'h0000, rate_act_ff}, 16'h0001);
    @(posedge mclk) sync_ref <= 1'b1;
    repeat (3) @(posedge mclk);
    check({15'h0000, rate_act_ff}, 16'h0000);
    @(posedge mclk) powerdown_pin_n <= 1'b0;
    repeat (8) @(posedge mclk);
    host.write_reg(RATE_ADDR, 16'hd2f0);
    repeat (2) @(posedge mclk);
    check(rate_ff, RATE_RESET);
    @(posedge mclk) powerdown_pin_n <= 1'b1;
    repeat (8) @(posedge mclk);
  endtask
  task automatic t_phase();
    int base;
    base = steps;
    host.write_reg(PHASE_ADDR, 16'h0105);
    repeat (100) @(posedge mclk);
    check(16'(steps - base), 16'h0005);
    check({15'h0000, dir_ff}, 16'h0001);
    host.read_reg(PHASE_ADDR, v);
    check(v, 16'h0100);
    host.write_reg(PHASE_ADDR, 16'h00ff);
    repeat (40) @(posedge mclk);
    host.read_reg(PHASE_ADDR, v);
    check({15'h0000, v >= 16'h00f0 && v <= 16'h00ff}, 16'h0001);
    host.write_reg(PHASE_ADDR, 16'h0002);
    @(posedge mclk);
    base = steps;
    repeat (100) @(posedge mclk);
    check(16'(steps - base), 16'h0002);
    check({15'h0000, dir_ff}, 16'h0000);
    @(posedge mclk) master_mode <= 1'b0;
    host.write_reg(PHASE_ADDR, 16'h0080);
    repeat (40) @(posedge mclk);
    host.read_reg(PHASE_ADDR, v);
    check(v, 16'h0000);
    @(posedge mclk) slave_fs <= 1'b1;
    repeat (4) @(posedge mclk);
    slave_fs <= 1'b0;
    repeat (8) @(posedge mclk);
    host.read_reg(PHASE_ADDR, v);
    check({15'h0000, v >= 16'h0060 && v <= 16'h0080}, 16'h0001);
    @(posedge mclk) gen3_enable <= 1'b0;
    host.write_reg(PHASE_ADDR, 16'h0010);
    repeat (40) @(posedge mclk);
    host.read_reg(PHASE_ADDR, v);
    check(v, PHASE_RESET);
  endtask
  task automatic t_filter();
    host.write_reg(RATE_ADDR, 16'h5dc0);
    for (int c = 0; c < 4; c++)
    begin
      host.write_reg(FILTER_ADDR, 16'(c * 16'h0050));
      repeat (2) @(posedge mclk);
      check({14'h0000, rpath_ff}, (c == 1) ? 16'h0000 : 16'(c));
      check({14'h0000, lpath_ff}, (c == 1) ? 16'h0000 : 16'(c));
    end
    host.write_reg(FILTER_ADDR, FILTER_MASK);
    host.read_reg(FILTER_ADDR, v);
    check(v, FILTER_MASK);
    check({15'h0000, filter_cfg_ff.resampler_filter_mode}, 16'h0001);
    check({14'h0000, rpath_ff}, 16'h0003);
    @(posedge mclk) chan_pd <= 4'h4;
    host.write_reg(FILTER_ADDR, 16'h0000);
    host.read_reg(FILTER_ADDR, v);
    check(v, 16'hc103);
    check({14'h0000, lpath_ff}, 16'h0000);
    @(posedge mclk) chan_pd <= 4'h0;
    host.write_reg(FILTER_ADDR, FILTER_MASK);
    host.read_reg(FILTER_ADDR, v);
    check(v, 16'hc1f3);
    host.read_reg(6'h3f, v);
    check(v, 16'h0000);
    @(posedge mclk) conv_pd <= 1'b1;
    repeat (4) @(posedge mclk);
    host.read_reg(FILTER_ADDR, v);
    check(v, FILTER_RESET);
  endtask
  // =====================================================
  // main sequence and watchdog
  initial
  begin
    sys_rst = 1'b1;
    {reset_pin_n, powerdown_pin_n, gen3_enable, master_mode} = 4'hf;
    {sync_ref, conv_pd, slave_fs} = 3'h0;
    chan_pd = 4'hf;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge mclk);
    t_rate();
    t_phase();
    t_filter();
    complete_run();
  end
  initial
  begin
    #40000;
    miscompares++;
    complete_run();
  end
endmodule // cg3_rate_phase_filter_cfg_tb
`default_nettype wire
